// File: hdl/scc_pkg.sv
package scc_pkg;
   // ****************************************
   // Task-file register selects
   // ****************************************
   localparam logic [2:0] SEL_FEATURES = 3'h1;
   localparam logic [2:0] SEL_SECTOR_COUNT = 3'h2;
   localparam logic [2:0] SEL_DEVICE_HEAD = 3'h6;
   localparam logic [2:0] SEL_COMMAND = 3'h7;
   localparam logic [2:0] SEL_ERROR = 3'h1;
   localparam logic [2:0] SEL_STATUS = 3'h7;

   // ****************************************
   // Command and field layout
   // ****************************************
   localparam logic [7:0] CMD_CONFIGURE_STREAM = 8'h51;
   localparam int FEAT_ADD_BIT = 7;
   localparam int FEAT_DIR_BIT = 6;
   localparam int FEAT_ID_HI = 2;
   localparam int ID_W = 3;
   localparam int NUM_STREAMS = 8;
   localparam int AU_W = 16;
   localparam int UNIT_W = 32;
   localparam int COMPLETION_TIME_LIMIT_W = 40;
   localparam int DESC_W = 1 + AU_W + COMPLETION_TIME_LIMIT_W;

   // ****************************************
   // Error and status bits
   // ****************************************
   localparam int ERR_ABORT_BIT = 2;
   localparam int ST_BUSY_BIT = 7;
   localparam int ST_READY_BIT = 6;
   localparam int ST_SEEK_DONE_BIT = 4;
   localparam int ST_ERR_BIT = 0;
   localparam logic [7:0] STATUS_RESET = 8'h50;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 100;
   localparam int US_NS = 1000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CYCLES_PER_US = US_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CALC,
      ST_COMMIT
   } scc_state_t;
endpackage

// File: hdl/scc_desc_mem.sv
`timescale 1ns/1ps
// Descriptor store, one entry per stream, registered read data
module scc_desc_mem #(
   parameter int DEPTH = 8,
   parameter int AW = 3,
   parameter int W = 57
) (
   input wire logic i_core_clk,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [W-1:0] i_wdata,
   input wire logic [AW-1:0] i_raddr,
   output logic [W-1:0] o_rdata
);
   logic [W-1:0] mem [DEPTH];

   // ****************************************
   // Storage and read register
   // ****************************************
   // No reset on the array; entry validity is tracked by the owner
   always_ff @(posedge i_core_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule

// File: hdl/scc_completion_time_limit_timer.sv
`timescale 1ns/1ps
// Microsecond countdown of one command's completion time limit
module scc_completion_time_limit_timer #(
   parameter int LIMIT_W = 40,
   parameter int TICKS_PER_US = 100
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_start,
   input wire logic [LIMIT_W-1:0] i_limit_us,
   input wire logic i_stop,
   output logic o_running,
   output logic o_expired
);
   localparam int PW = $clog2(TICKS_PER_US + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(TICKS_PER_US - 1);

   logic [PW-1:0] pre_r;
   logic [LIMIT_W-1:0] left_r;
   logic run_r;
   logic exp_r;
   wire us_tick = run_r && (pre_r == PRE_LAST);
   wire hit_zero = us_tick && (left_r <= LIMIT_W'(1));

   assign o_running = run_r;
   assign o_expired = exp_r;

   // ****************************************
   // Prescaler and countdown
   // ****************************************
   // Stop wins over expiry so a completion on the last tick is on time
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pre_r <= '0;
         left_r <= '0;
         run_r <= 1'b0;
         exp_r <= 1'b0;
      end else if (i_start) begin
         pre_r <= '0;
         left_r <= i_limit_us;
         run_r <= (i_limit_us != '0);
         exp_r <= 1'b0;
      end else if (i_stop) begin
         run_r <= 1'b0;
      end else if (run_r) begin
         pre_r <= us_tick ? '0 : pre_r + PW'(1);
         if (us_tick) begin
            left_r <= left_r - LIMIT_W'(1);
         end
         if (hit_zero) begin
            run_r <= 1'b0;
            exp_r <= 1'b1;
         end
      end
   end
endmodule

// File: hdl/scc_stream_config.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Command code 51h selects stream configuration.
// - Add over valid stream replaces; abort keeps old.
// - Abort when streaming feature is unsupported.
// - Abort removal of never-configured stream identifier.
// - Feature bit 7 is add/remove flag.
// - Feature bit 6 stores read/write direction.
// - Feature bits 2:0 give stream identifier 0-7.
// - Limit = previous feature times time unit.
// - Zero requested limit uses stored default.
// - Limit measured from command write to interrupt; here the timer runs from the lookup answer until i_lk_done.
// - Limit below minimum is raised to minimum.
// - Previous sector count is allocation size high.
// - Abort sets abort bit and error; busy clear.
module scc_stream_config #(
   parameter int NUM_STREAMS = scc_pkg::NUM_STREAMS,
   parameter int TICKS_PER_US = scc_pkg::CYCLES_PER_US
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // Task-file access from the host link
   input wire logic i_tf_wr,
   input wire logic i_tf_rd,
   input wire logic [2:0] i_tf_sel,
   input wire logic [7:0] i_tf_wdata,
   input wire logic i_high_order_byte_select,
   output logic [7:0] o_tf_rdata,
   output logic o_intrq,
   // Device configuration
   input wire logic i_streaming_supported,
   input wire logic [scc_pkg::UNIT_W-1:0] i_time_unit,
   input wire logic [scc_pkg::COMPLETION_TIME_LIMIT_W-1:0] i_min_completion_time_limit,
   // Later streaming command lookup
   input wire logic i_lk_req,
   input wire logic [scc_pkg::ID_W-1:0] i_lk_id,
   input wire logic [scc_pkg::COMPLETION_TIME_LIMIT_W-1:0] i_lk_completion_time_limit,
   input wire logic i_lk_done,
   output logic o_lk_valid,
   output logic o_lk_hit,
   output logic o_lk_dir,
   output logic [scc_pkg::AU_W-1:0] o_lk_au,
   output logic [scc_pkg::COMPLETION_TIME_LIMIT_W-1:0] o_lk_completion_time_limit,
   output logic o_completion_time_limit_running,
   output logic o_completion_time_limit_expired,
   output logic [NUM_STREAMS-1:0] o_stream_valid
);
   // ****************************************
   // Shadow task-file registers
   // ****************************************
   logic [7:0] feat_cur_r;
   logic [7:0] feat_prev_r;
   logic [7:0] sc_cur_r;
   logic [7:0] sc_prev_r;
   logic [7:0] dev_head_r;
   logic [7:0] error_r;
   logic [7:0] status_r;
   logic intrq_r;
   scc_pkg::scc_state_t state_r;
   scc_pkg::scc_state_t state_nxt;
   logic [NUM_STREAMS-1:0] valid_r;
   logic [scc_pkg::COMPLETION_TIME_LIMIT_W-1:0] completion_time_limit_r;
   logic abort_r;
   logic [scc_pkg::ID_W-1:0] id_r;
   logic add_r;
   logic dir_r;
   logic [scc_pkg::AU_W-1:0] au_r;

   wire busy = (state_r != scc_pkg::ST_IDLE);
   wire wr_feat = i_tf_wr && (i_tf_sel == scc_pkg::SEL_FEATURES);
   wire wr_sc = i_tf_wr && (i_tf_sel == scc_pkg::SEL_SECTOR_COUNT);
   wire wr_dh = i_tf_wr && (i_tf_sel == scc_pkg::SEL_DEVICE_HEAD);
   wire wr_cmd = i_tf_wr && (i_tf_sel == scc_pkg::SEL_COMMAND);
   // Command writes while busy are dropped, as on a real task file
   wire cmd_start = wr_cmd && !busy && (i_tf_wdata == scc_pkg::CMD_CONFIGURE_STREAM);

   // ****************************************
   // Field decode of the latched parameters
   // ****************************************
   wire feat_add = feat_cur_r[scc_pkg::FEAT_ADD_BIT];
   wire feat_dir = feat_cur_r[scc_pkg::FEAT_DIR_BIT];
   wire [scc_pkg::ID_W-1:0] feat_id = feat_cur_r[scc_pkg::FEAT_ID_HI:0];
   wire [scc_pkg::AU_W-1:0] feat_au = {sc_prev_r, sc_cur_r};
   // Product is exact: 8 by 32 bits fits the 40-bit limit
   wire [scc_pkg::COMPLETION_TIME_LIMIT_W-1:0] completion_time_limit_raw = scc_pkg::COMPLETION_TIME_LIMIT_W'(feat_prev_r) * scc_pkg::COMPLETION_TIME_LIMIT_W'(i_time_unit);
   wire [scc_pkg::COMPLETION_TIME_LIMIT_W-1:0] completion_time_limit_clamped = (completion_time_limit_raw < i_min_completion_time_limit) ? i_min_completion_time_limit : completion_time_limit_raw;
   wire abort_unsup = !i_streaming_supported;
   wire abort_remove = !add_r && !valid_r[id_r];
   wire commit_ok = (state_r == scc_pkg::ST_COMMIT) && !abort_r;
   wire mem_we = commit_ok && add_r;
   wire [scc_pkg::DESC_W-1:0] mem_wdata = {dir_r, au_r, completion_time_limit_r};
   wire [scc_pkg::DESC_W-1:0] mem_rdata;

   // ****************************************
   // Host writes into the shadow registers
   // ****************************************
   // Each features or sector count byte write while idle pushes the old current value into previous
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         feat_cur_r <= scc_pkg::ZERO_BYTE;
         feat_prev_r <= scc_pkg::ZERO_BYTE;
         sc_cur_r <= scc_pkg::ZERO_BYTE;
         sc_prev_r <= scc_pkg::ZERO_BYTE;
         dev_head_r <= scc_pkg::ZERO_BYTE;
      end else if (!busy) begin
         if (wr_feat) begin
            feat_prev_r <= feat_cur_r;
            feat_cur_r <= i_tf_wdata;
         end
         if (wr_sc) begin
            sc_prev_r <= sc_cur_r;
            sc_cur_r <= i_tf_wdata;
         end
         if (wr_dh) begin
            dev_head_r <= i_tf_wdata;
         end
      end
   end

   // ****************************************
   // Command sequencer
   // ****************************************
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         scc_pkg::ST_IDLE: begin
            if (cmd_start) begin
               state_nxt = scc_pkg::ST_CALC;
            end
         end
         scc_pkg::ST_CALC: begin
            state_nxt = scc_pkg::ST_COMMIT;
         end
         scc_pkg::ST_COMMIT: begin
            state_nxt = scc_pkg::ST_IDLE;
         end
         default: begin
            state_nxt = scc_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r <= scc_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Parameters captured at the command write, so later shadow writes cannot alter them
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         id_r <= '0;
         add_r <= 1'b0;
         dir_r <= 1'b0;
         au_r <= '0;
         completion_time_limit_r <= '0;
      end else if (cmd_start) begin
         id_r <= feat_id;
         add_r <= feat_add;
         dir_r <= feat_dir;
         au_r <= feat_au;
         completion_time_limit_r <= completion_time_limit_clamped;
      end
   end

   // Abort decision settles one cycle after capture
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         abort_r <= 1'b0;
      end else if (state_r == scc_pkg::ST_CALC) begin
         abort_r <= abort_unsup || abort_remove;
      end
   end

   // ****************************************
   // Stream validity, one flag per identifier
   // ****************************************
   // An aborted command touches neither flag nor descriptor
   genvar g;
   generate
      for (g = 0; g < NUM_STREAMS; g++) begin : g_valid
         always_ff @(posedge i_core_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               valid_r[g] <= 1'b0;
            end else if (commit_ok && (id_r == scc_pkg::ID_W'(g))) begin
               valid_r[g] <= add_r;
            end
         end
      end
   endgenerate
   assign o_stream_valid = valid_r;

   // ****************************************
   // Completion: error, status, interrupt
   // ****************************************
   // Busy shows from the command write until the interrupt
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         error_r <= scc_pkg::ZERO_BYTE;
         status_r <= scc_pkg::STATUS_RESET;
         intrq_r <= 1'b0;
      end else if (cmd_start) begin
         status_r <= scc_pkg::ZERO_BYTE;
         status_r[scc_pkg::ST_BUSY_BIT] <= 1'b1;
         intrq_r <= 1'b0;
      end else if (state_r == scc_pkg::ST_COMMIT) begin
         error_r <= scc_pkg::ZERO_BYTE;
         error_r[scc_pkg::ERR_ABORT_BIT] <= abort_r;
         status_r <= scc_pkg::ZERO_BYTE;
         status_r[scc_pkg::ST_READY_BIT] <= 1'b1;
         status_r[scc_pkg::ST_SEEK_DONE_BIT] <= 1'b1;
         status_r[scc_pkg::ST_ERR_BIT] <= abort_r;
         intrq_r <= 1'b1;
      end else begin
         intrq_r <= 1'b0;
      end
   end
   assign o_intrq = intrq_r;

   // ****************************************
   // Task-file read path
   // ****************************************
   // Selector picks the previous sector count byte when high order byte select is set
   wire [7:0] rd_sc = i_high_order_byte_select ? sc_prev_r : sc_cur_r;
   wire [7:0] rd_mux = (i_tf_sel == scc_pkg::SEL_ERROR) ? error_r :
                       (i_tf_sel == scc_pkg::SEL_STATUS) ? status_r :
                       (i_tf_sel == scc_pkg::SEL_SECTOR_COUNT) ? rd_sc :
                       (i_tf_sel == scc_pkg::SEL_DEVICE_HEAD) ? dev_head_r : scc_pkg::ZERO_BYTE;

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_tf_rdata <= scc_pkg::ZERO_BYTE;
      end else if (i_tf_rd) begin
         o_tf_rdata <= rd_mux;
      end
   end

   // ****************************************
   // Descriptor store
   // ****************************************
   scc_desc_mem #(
      .DEPTH(NUM_STREAMS),
      .AW(scc_pkg::ID_W),
      .W(scc_pkg::DESC_W)
   ) u_mem (
      .i_core_clk(i_core_clk),
      .i_we(mem_we),
      .i_waddr(id_r),
      .i_wdata(mem_wdata),
      .i_raddr(i_lk_id),
      .o_rdata(mem_rdata)
   );

   // ****************************************
   // Lookup for later streaming commands
   // ****************************************
   logic lk_pend_r;
   logic lk_hit_r;
   logic [scc_pkg::COMPLETION_TIME_LIMIT_W-1:0] lk_req_r;
   wire [scc_pkg::COMPLETION_TIME_LIMIT_W-1:0] stored_completion_time_limit = mem_rdata[scc_pkg::COMPLETION_TIME_LIMIT_W-1:0];
   // Zero request falls back on the stored default
   wire [scc_pkg::COMPLETION_TIME_LIMIT_W-1:0] lk_eff = (lk_req_r == '0 && lk_hit_r) ? stored_completion_time_limit : lk_req_r;

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         lk_pend_r <= 1'b0;
         lk_hit_r <= 1'b0;
         lk_req_r <= '0;
      end else begin
         lk_pend_r <= i_lk_req;
         if (i_lk_req) begin
            lk_hit_r <= valid_r[i_lk_id];
            lk_req_r <= i_lk_completion_time_limit;
         end
      end
   end

   // Results registered; they stand until the next lookup answers
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_lk_valid <= 1'b0;
         o_lk_hit <= 1'b0;
         o_lk_dir <= 1'b0;
         o_lk_au <= '0;
         o_lk_completion_time_limit <= '0;
      end else begin
         o_lk_valid <= lk_pend_r;
         if (lk_pend_r) begin
            o_lk_hit <= lk_hit_r;
            o_lk_dir <= lk_hit_r & mem_rdata[scc_pkg::DESC_W-1];
            o_lk_au <= lk_hit_r ? mem_rdata[scc_pkg::COMPLETION_TIME_LIMIT_W +: scc_pkg::AU_W] : '0;
            o_lk_completion_time_limit <= lk_eff;
         end
      end
   end

   // ****************************************
   // Completion time limit watch
   // ****************************************
   // Timer starts on the lookup answer; the limit runs until i_lk_done stops it
   scc_completion_time_limit_timer #(
      .LIMIT_W(scc_pkg::COMPLETION_TIME_LIMIT_W),
      .TICKS_PER_US(TICKS_PER_US)
   ) u_timer (
      .i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n),
      .i_start(o_lk_valid),
      .i_limit_us(o_lk_completion_time_limit),
      .i_stop(i_lk_done),
      .o_running(o_completion_time_limit_running),
      .o_expired(o_completion_time_limit_expired)
   );
endmodule

// File: sim/scc_stream_config_asserts.sv
`timescale 1ns/1ps
// ****************************************
// Port-level checker
// ****************************************
module scc_stream_config_asserts #(
   parameter int NUM_STREAMS = 8
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_tf_wr,
   input wire logic i_tf_rd,
   input wire logic [2:0] i_tf_sel,
   input wire logic [7:0] i_tf_wdata,
   input wire logic [7:0] o_tf_rdata,
   input wire logic o_intrq,
   input wire logic i_streaming_supported,
   input wire logic [39:0] i_min_completion_time_limit,
   input wire logic i_lk_req,
   input wire logic [39:0] i_lk_completion_time_limit,
   input wire logic i_lk_done,
   input wire logic o_lk_valid,
   input wire logic o_lk_hit,
   input wire logic [39:0] o_lk_completion_time_limit,
   input wire logic o_completion_time_limit_running,
   input wire logic [NUM_STREAMS-1:0] o_stream_valid
);
   logic [1:0] busy_r;
   logic [1:0] busy_nxt;
   logic take_cmd;
   logic st_rd;
   // Mirror of the busy window; writes inside it are refused
   assign take_cmd = i_tf_wr && i_tf_sel == scc_pkg::SEL_COMMAND && i_tf_wdata == scc_pkg::CMD_CONFIGURE_STREAM &&
      busy_r == 2'h0;
   assign st_rd = i_tf_rd && i_tf_sel == scc_pkg::SEL_STATUS;
   assign busy_nxt = take_cmd ? 2'h2 : (busy_r != 2'h0 ? busy_r - 2'h1 : 2'h0);
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) busy_r <= 2'h0;
      else busy_r <= busy_nxt;
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   sequence s_take; take_cmd; endsequence
   sequence s_done; ##3 o_intrq; endsequence
   chk_intrq_latency: assert property (s_take |-> s_done)
      else $error("interrupt not three cycles after command");
   chk_intrq_cause: assert property (o_intrq |-> $past(take_cmd, 3))
      else $error("interrupt without command");
   chk_valid_commit: assert property ($changed(o_stream_valid) |-> o_intrq)
      else $error("stream flags changed outside completion");
   chk_unsupported_keep: assert property (s_take ##0 !i_streaming_supported |-> ##3 $stable(o_stream_valid))
      else $error("flags changed on unsupported device");
   chk_error_zero: assert property (i_tf_rd && i_tf_sel == scc_pkg::SEL_ERROR |=> o_tf_rdata[7:3] == 5'h00 &&
      o_tf_rdata[1:0] == 2'h0)
      else $error("unused error bits set");
   chk_busy_read: assert property (st_rd && busy_r != 2'h0 |=> o_tf_rdata == 8'h80)
      else $error("status not busy during command");
   chk_idle_status: assert property (st_rd && busy_r == 2'h0 && $past(busy_r) == 2'h0 |=> !o_tf_rdata[7])
      else $error("busy set while idle");
   chk_lookup_answer: assert property (i_lk_req |-> ##2 o_lk_valid)
      else $error("lookup answer late");
   chk_given_limit: assert property (o_lk_valid && $past(i_lk_completion_time_limit, 2) != 40'h0 |-> o_lk_completion_time_limit == $past(i_lk_completion_time_limit, 2))
      else $error("given limit not passed");
   chk_min_clamp: assert property (o_lk_valid && o_lk_hit && $past(i_lk_completion_time_limit, 2) == 40'h0 |-> o_lk_completion_time_limit >= i_min_completion_time_limit)
      else $error("default limit below minimum");
   // A fresh lookup answer in the same cycle restarts the timer, so it is left out
   chk_stop_timer: assert property (i_lk_done && !o_lk_valid |=> !o_completion_time_limit_running)
      else $error("timer runs after completion");
endmodule

bind scc_stream_config scc_stream_config_asserts #(.NUM_STREAMS(NUM_STREAMS)) u_chk (.i_core_clk, .i_reset_n,
   .i_tf_wr, .i_tf_rd, .i_tf_sel, .i_tf_wdata, .o_tf_rdata, .o_intrq, .i_streaming_supported, .i_min_completion_time_limit,
   .i_lk_req, .i_lk_completion_time_limit, .i_lk_done, .o_lk_valid, .o_lk_hit, .o_lk_completion_time_limit, .o_completion_time_limit_running, .o_stream_valid);

// File: sim/scc_host_model.sv
`timescale 1ns/1ps
// ****************************************
// Host controller model
// ****************************************
module scc_host_model (
   input wire logic i_core_clk,
   input wire logic i_intrq,
   input wire logic [7:0] i_rdata,
   output logic o_wr,
   output logic o_rd,
   output logic [2:0] o_sel,
   output logic [7:0] o_wdata,
   output logic o_hob
);
   // Quiet bus at time zero
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_sel = 3'h0;
      o_wdata = 8'h00;
      o_hob = 1'b0;
   end
   // Byte write; released data inverted so no stale value reads as valid
   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      @(posedge i_core_clk);
      o_wr <= 1'b1;
      o_sel <= s;
      o_wdata <= d;
      @(posedge i_core_clk);
      o_wr <= 1'b0;
      o_wdata <= ~d;
   endtask
   // Byte read, taken once the registered answer settles
   task automatic rd(input logic [2:0] s, input logic h, output logic [7:0] q);
      @(posedge i_core_clk);
      o_rd <= 1'b1;
      o_sel <= s;
      o_hob <= h;
      @(posedge i_core_clk);
      o_rd <= 1'b0;
      @(negedge i_core_clk);
      q = i_rdata;
   endtask
   // One whole command per stream change, then count completion pulses
   task automatic cmd(input logic [7:0] fp, input logic [7:0] fc, input logic [15:0] au, input logic [7:0] code,
      output logic [3:0] n);
      logic [7:0] b;
      wr(3'h1, fp);
      wr(3'h1, fc);
      wr(3'h2, au[15:8]);
      wr(3'h2, au[7:0]);
      wr(3'h7, code);
      // Status poll inside the busy window; its answer settles with the interrupt
      rd(3'h7, 1'b0, b);
      n = (i_intrq === 1'b1) ? 4'h1 : 4'h0;
      repeat (6) begin
         @(negedge i_core_clk);
         if (i_intrq === 1'b1) n = n + 4'h1;
      end
   endtask
endmodule

// File: sim/scc_stream_config_bench.sv
`timescale 1ns/1ps
// ****************************************
// Bench top
// ****************************************
module scc_stream_config_bench;
   logic i_core_clk = 1'b0;
   logic i_reset_n, i_tf_wr, i_tf_rd, i_high_order_byte_select, o_intrq, i_streaming_supported;
   logic i_lk_req, i_lk_done, o_lk_valid, o_lk_hit, o_lk_dir, o_completion_time_limit_running, o_completion_time_limit_expired;
   logic [2:0] i_tf_sel, i_lk_id;
   logic [7:0] i_tf_wdata, o_tf_rdata, o_stream_valid, q;
   logic [15:0] o_lk_au;
   logic [31:0] i_time_unit;
   logic [39:0] i_min_completion_time_limit, i_lk_completion_time_limit, o_lk_completion_time_limit;
   logic [3:0] n;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;
   localparam logic [7:0] CFG = scc_pkg::CMD_CONFIGURE_STREAM;
   always #5 i_core_clk = ~i_core_clk;
   // Timer ticks shortened to two cycles per microsecond
   scc_stream_config #(.TICKS_PER_US(2)) DUT (.i_core_clk, .i_reset_n, .i_tf_wr, .i_tf_rd, .i_tf_sel, .i_tf_wdata,
      .i_high_order_byte_select, .o_tf_rdata, .o_intrq, .i_streaming_supported, .i_time_unit, .i_min_completion_time_limit,
      .i_lk_req, .i_lk_id, .i_lk_completion_time_limit, .i_lk_done, .o_lk_valid, .o_lk_hit, .o_lk_dir, .o_lk_au, .o_lk_completion_time_limit,
      .o_completion_time_limit_running, .o_completion_time_limit_expired, .o_stream_valid);
   scc_host_model host (.i_core_clk, .i_intrq(o_intrq), .i_rdata(o_tf_rdata), .o_wr(i_tf_wr), .o_rd(i_tf_rd),
      .o_sel(i_tf_sel), .o_wdata(i_tf_wdata), .o_hob(i_high_order_byte_select));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Status then error readback
   task automatic st(input logic [7:0] es, input logic [7:0] ee);
      host.rd(scc_pkg::SEL_STATUS, 1'b0, q);
      check("status", q, es);
      host.rd(scc_pkg::SEL_ERROR, 1'b0, q);
      check("error", q, ee);
   endtask
   // Later streaming command lookup, answer two cycles on
   task automatic lk(input logic [2:0] id, input logic [39:0] lim);
      @(posedge i_core_clk);
      i_lk_req <= 1'b1;
      i_lk_id <= id;
      i_lk_completion_time_limit <= lim;
      @(posedge i_core_clk);
      i_lk_req <= 1'b0;
      @(posedge i_core_clk);
      @(negedge i_core_clk);
      check("lk_valid", o_lk_valid, 1'b1);
   endtask
   // Hang guard, over ten times the expected run
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 6000) begin
         miscompares++;
         end_sim();
      end
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      i_reset_n = 1'b0;
      i_streaming_supported = 1'b1;
      i_time_unit = 32'h3;
      i_min_completion_time_limit = 40'h5;
      i_lk_req = 1'b0;
      i_lk_id = 3'h0;
      i_lk_completion_time_limit = 40'h0;
      i_lk_done = 1'b0;
      repeat (5) @(posedge i_core_clk);
      i_reset_n <= 1'b1;
      st(8'h50, 8'h00);
      // Removing a stream never configured aborts
      host.cmd(8'h04, 8'h03, 16'h1234, CFG, n);
      check("intrq", n, 4'h1);
      st(8'h51, 8'h04);
      check("valid", o_stream_valid, 8'h00);
      // Add write stream 5, limit 4 x 3 us
      host.cmd(8'h04, 8'hC5, 16'h1234, CFG, n);
      st(8'h50, 8'h00);
      check("valid", o_stream_valid, 8'h20);
      host.rd(scc_pkg::SEL_SECTOR_COUNT, 1'b1, q);
      check("sc_prev", q, 8'h12);
      host.rd(scc_pkg::SEL_SECTOR_COUNT, 1'b0, q);
      check("sc_cur", q, 8'h34);
      lk(3'h5, 40'h0);
      check("hit", o_lk_hit, 1'b1);
      check("dir", o_lk_dir, 1'b1);
      check("au", o_lk_au, 16'h1234);
      check("limit", o_lk_completion_time_limit, 40'hC);
      // 12 us at two cycles each
      repeat (20) @(negedge i_core_clk);
      check("running", o_completion_time_limit_running, 1'b1);
      repeat (7) @(negedge i_core_clk);
      check("expired", o_completion_time_limit_expired, 1'b1);
      // Replace stream 5: read, 3 us raised to minimum
      host.cmd(8'h01, 8'h85, 16'h0011, CFG, n);
      st(8'h50, 8'h00);
      lk(3'h5, 40'h0);
      check("dir", o_lk_dir, 1'b0);
      check("au", o_lk_au, 16'h0011);
      check("limit", o_lk_completion_time_limit, 40'h5);
      @(posedge i_core_clk);
      i_lk_done <= 1'b1;
      @(posedge i_core_clk);
      i_lk_done <= 1'b0;
      repeat (15) @(negedge i_core_clk);
      check("running", o_completion_time_limit_running, 1'b0);
      check("expired", o_completion_time_limit_expired, 1'b0);
      // Unsupported device aborts and keeps the old descriptor
      @(posedge i_core_clk);
      i_streaming_supported <= 1'b0;
      host.cmd(8'h09, 8'hC5, 16'hFFFF, CFG, n);
      st(8'h51, 8'h04);
      lk(3'h5, 40'h7);
      check("limit", o_lk_completion_time_limit, 40'h7);
      check("au", o_lk_au, 16'h0011);
      @(posedge i_core_clk);
      i_streaming_supported <= 1'b1;
      // Other command codes are ignored
      host.cmd(8'h01, 8'hC5, 16'h0022, 8'h50, n);
      check("intrq", n, 4'h0);
      st(8'h51, 8'h04);
      // Remove stream 5, then fill all eight
      host.cmd(8'h00, 8'h05, 16'h0000, CFG, n);
      st(8'h50, 8'h00);
      lk(3'h5, 40'h9);
      check("hit", o_lk_hit, 1'b0);
      for (int i = 0; i < 8; i++) begin
         host.cmd(8'h02, {1'b1, i[0], 3'h0, i[2:0]}, 16'(16'h0100 + i), CFG, n);
      end
      check("valid", o_stream_valid, 8'hFF);
      lk(3'h7, 40'h0);
      check("dir", o_lk_dir, 1'b1);
      check("au", o_lk_au, 16'h0107);
      check("limit", o_lk_completion_time_limit, 40'h6);
      // Shadow write while the command is busy is dropped
      host.wr(scc_pkg::SEL_COMMAND, CFG);
      host.wr(scc_pkg::SEL_SECTOR_COUNT, 8'hAA);
      repeat (4) @(negedge i_core_clk);
      host.rd(scc_pkg::SEL_SECTOR_COUNT, 1'b0, q);
      check("sc_busy", q, 8'h07);
      // Device select byte is stored and read back
      host.wr(scc_pkg::SEL_DEVICE_HEAD, 8'hE0);
      host.rd(scc_pkg::SEL_DEVICE_HEAD, 1'b0, q);
      check("dev_head", q, 8'hE0);
      end_sim();
   end
endmodule
